//--- rtl/pscs_pkg.sv
// shared constants and types of the power shelf supervisor
package pscs_pkg;
  localparam int unsigned NUM_MODULES = 6;
  localparam int unsigned CNT_W = 24;
  localparam int unsigned CLK_KHZ = 20000;
  localparam int unsigned OC_BLANK_MS = 22;
  localparam int unsigned OC_BLANK_CYC = OC_BLANK_MS * CLK_KHZ;
  localparam int unsigned SC_LATCH_MS = 10;
  localparam int unsigned SC_LATCH_CYC = SC_LATCH_MS * CLK_KHZ;
  localparam int unsigned OVERLOAD_MAX_MS = 20;
  localparam int unsigned OVERLOAD_CYC = OVERLOAD_MAX_MS * CLK_KHZ;
  localparam int unsigned HICCUP_OFF_MS = 100;
  localparam int unsigned HICCUP_CYC = HICCUP_OFF_MS * CLK_KHZ;
  localparam int unsigned BLINK_STEP_MS = 250;
  localparam int unsigned BLINK_CYC = BLINK_STEP_MS * CLK_KHZ;

  localparam logic [7:0] CMD_OPERATION = 8'h01;
  localparam logic [7:0] CMD_ON_OFF_CFG = 8'h02;
  localparam logic [7:0] OP_OFF = 8'h00;
  localparam logic [7:0] OP_ON = 8'h80;
  localparam logic [7:0] OP_RESET = 8'h80;
  localparam logic [7:0] CFG_RESET = 8'h1d;
  localparam logic [7:0] CFG_ALT0 = 8'h01;
  localparam logic [7:0] CFG_ALT1 = 8'h11;
  localparam logic [7:0] CFG_ALT2 = 8'h15;
  localparam logic [7:0] CFG_ALT3 = 8'h19;
  localparam int unsigned CFG_PIN_BIT = 3;
  localparam int unsigned CFG_CMD_BIT = 2;
  localparam int unsigned OP_ON_BIT = 7;
  localparam logic [7:0] READ_FILL = 8'h00;
  localparam logic [7:0] CTRL_ADDR_BASE = 8'h50;
  localparam logic [7:0] MUX_ADDR_BASE = 8'he0;
  localparam logic [7:0] CTRL_ADDR_RESET = 8'h5e;
  localparam logic [7:0] MUX_ADDR_RESET = 8'hee;
  localparam logic [7:0] MODULE_ADDR = 8'h20;

  typedef struct packed {
    logic present;
    logic inputGood;
    logic operating;
    logic ovMain;
    logic ovStby;
    logic ocMain;
    logic scMain;
    logic ocStby;
    logic overload;
    logic acUv;
    logic outOfReg;
    logic otShutdown;
    logic uvShutdown;
    logic otWarn;
    logic fanMinor;
  } pscs_mod_s;

  typedef struct packed {
    logic acGreen;
    logic dcGreen;
    logic dcYellow;
  } pscs_led_s;

  typedef enum logic [2:0] {
    I2C_IDLE, I2C_ADDR, I2C_CMD, I2C_WDATA, I2C_RDATA, I2C_SKIP
  } pscs_i2c_e;

  function automatic logic pscs_cfg_ok(input logic [7:0] v);
    return (v == CFG_RESET) || (v == CFG_ALT0) || (v == CFG_ALT1) ||
           (v == CFG_ALT2) || (v == CFG_ALT3);
  endfunction
endpackage

//--- rtl/pscs_shelf_ctrl.sv
// power shelf supervisor: fault latches, shared pins, leds, control port
// Operation
// - overvoltage on either output latches it off
// - sustained main overcurrent latches after 22 ms
// - main short circuit latches after 10 ms
// - standby overcurrent enters hiccup, no latch
// - raised-limit overload cut after 20 ms
// - power good pulled low if any operating
// - input good pulled low if any input good
// - modules start together once inputs good
// - low shelf enable turns main output on
// - shelf enable high clears latched faults
// - low mux reset request resets the mux
// - all modules answer at address 0x20
// - switch bits set mux and controller addresses
// - switches all on give 0xEE and 0x5E
// - output on command 0x01, values 0x00/0x80
// - on/off config 0x02, five supported values
// - config returns to default after reset
// - commands may switch main output too
// - ac led green unless input undervoltage
// - dc led green, blinks yellow when disabled
// - dc led solid yellow on any shutdown
// - dc led alternates for fan, temperature warn
// - led conditions evaluated in fixed priority
`timescale 1ns/1ps
module pscs_shelf_ctrl
  import pscs_pkg::*;
#(
  parameter logic [CNT_W-1:0] OC_BLANK_LIM = CNT_W'(OC_BLANK_CYC),
  parameter logic [CNT_W-1:0] SC_LATCH_LIM = CNT_W'(SC_LATCH_CYC),
  parameter logic [CNT_W-1:0] OVERLOAD_LIM = CNT_W'(OVERLOAD_CYC),
  parameter logic [CNT_W-1:0] HICCUP_LIM = CNT_W'(HICCUP_CYC),
  parameter logic [CNT_W-1:0] BLINK_LIM = CNT_W'(BLINK_CYC)
) (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic i2cSampleClk,
  input wire logic sclIn,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOeN,
  input wire logic shelfEnableN,
  input wire logic muxResetReqN,
  output logic muxResetN,
  input wire logic [2:0] addressSwitch,
  output logic [7:0] muxAddr,
  output logic [7:0] ctrlAddr,
  output logic [7:0] moduleAddr,
  input pscs_mod_s [NUM_MODULES-1:0] moduleStatus,
  output logic [NUM_MODULES-1:0] moduleEnableN,
  output logic [NUM_MODULES-1:0] mainLatchOff,
  output logic [NUM_MODULES-1:0] stbyLatchOff,
  output logic [NUM_MODULES-1:0] stbyHiccup,
  output pscs_led_s [NUM_MODULES-1:0] ledState,
  output logic powerGoodOut,
  output logic powerGoodOeN,
  output logic inputGoodOut,
  output logic inputGoodOeN
);

  // link domain: i2c slave, straps and command registers
  logic [1:0] linkRstPipe;
  logic linkRstN;
  logic [1:0] sclPipe;
  logic [1:0] sdaPipe;
  logic sclDly;
  logic sdaDly;
  logic [2:0] swPipe1;
  logic [2:0] swPipe2;
  logic strapTaken_r;
  logic [7:0] ctrlAddr_r;
  logic [7:0] muxAddr_r;
  pscs_i2c_e state_r;
  logic [3:0] bitCnt_r;
  logic ackPh_r;
  logic [7:0] rxSh_r;
  logic [7:0] txSh_r;
  logic [7:0] cmd_r;
  logic sdaOeN_r;
  logic [7:0] opLink_r;
  logic [7:0] cfgLink_r;
  logic wrTgl_r;
  logic startCond;
  logic stopCond;
  logic sclRise;
  logic sclFall;
  logic byteEnd;
  logic dataValid;
  logic wrNow;
  logic addrHit;
  logic [7:0] rdVal;

  // reset is released into the link domain two link edges late
  always_ff @(posedge i2cSampleClk) begin
    linkRstPipe <= {linkRstPipe[0], resetn};
  end
  assign linkRstN = linkRstPipe[1];

  always_ff @(posedge i2cSampleClk) begin
    if (!linkRstN) begin
      sclPipe <= 2'h3;
      sdaPipe <= 2'h3;
      sclDly <= 1'b1;
      sdaDly <= 1'b1;
    end else begin
      sclPipe <= {sclPipe[0], sclIn};
      sdaPipe <= {sdaPipe[0], sdaIn};
      sclDly <= sclPipe[1];
      sdaDly <= sdaPipe[1];
    end
  end

  // switch synchroniser runs free so it is settled at reset release
  always_ff @(posedge i2cSampleClk) begin
    swPipe1 <= addressSwitch;
    swPipe2 <= swPipe1;
  end

  // straps are caught once, at the first edge after release
  always_ff @(posedge i2cSampleClk) begin
    if (!linkRstN) begin
      strapTaken_r <= 1'b0;
      ctrlAddr_r <= CTRL_ADDR_RESET;
      muxAddr_r <= MUX_ADDR_RESET;
    end else if (!strapTaken_r) begin
      strapTaken_r <= 1'b1;
      ctrlAddr_r <= CTRL_ADDR_BASE | {4'h0, swPipe2, 1'b0};
      muxAddr_r <= MUX_ADDR_BASE | {4'h0, swPipe2, 1'b0};
    end
  end

  assign startCond = sclPipe[1] & sdaDly & ~sdaPipe[1];
  assign stopCond = sclPipe[1] & ~sdaDly & sdaPipe[1];
  assign sclRise = sclPipe[1] & ~sclDly;
  assign sclFall = ~sclPipe[1] & sclDly;
  assign byteEnd = sclFall & ~ackPh_r & (bitCnt_r == 4'h8);
  assign addrHit = (rxSh_r[7:1] == ctrlAddr_r[7:1]);

  always_comb begin
    dataValid = 1'b0;
    if (cmd_r == CMD_OPERATION) begin
      dataValid = (rxSh_r == OP_OFF) || (rxSh_r == OP_ON);
    end else if (cmd_r == CMD_ON_OFF_CFG) begin
      dataValid = pscs_cfg_ok(rxSh_r);
    end
  end

  always_comb begin
    rdVal = READ_FILL;
    if (cmd_r == CMD_OPERATION) begin
      rdVal = opLink_r;
    end else if (cmd_r == CMD_ON_OFF_CFG) begin
      rdVal = cfgLink_r;
    end
  end

  assign wrNow = byteEnd & (state_r == I2C_WDATA) & dataValid;

  // byte-level slave: samples on scl rise, drives sda after scl fall
  always_ff @(posedge i2cSampleClk) begin
    if (!linkRstN) begin
      state_r <= I2C_IDLE;
      bitCnt_r <= 4'h0;
      ackPh_r <= 1'b0;
      rxSh_r <= 8'h00;
      txSh_r <= 8'h00;
      cmd_r <= 8'h00;
      sdaOeN_r <= 1'b1;
    end else if (startCond) begin
      state_r <= I2C_ADDR;
      bitCnt_r <= 4'h0;
      ackPh_r <= 1'b0;
      sdaOeN_r <= 1'b1;
    end else if (stopCond) begin
      state_r <= I2C_IDLE;
      bitCnt_r <= 4'h0;
      ackPh_r <= 1'b0;
      sdaOeN_r <= 1'b1;
    end else if (state_r != I2C_IDLE) begin
      if (sclRise) begin
        if (!ackPh_r) begin
          rxSh_r <= {rxSh_r[6:0], sdaPipe[1]};
          bitCnt_r <= bitCnt_r + 4'h1;
        end else if (state_r == I2C_RDATA && sdaPipe[1]) begin
          state_r <= I2C_SKIP;
        end
      end
      if (byteEnd) begin
        ackPh_r <= 1'b1;
        bitCnt_r <= 4'h0;
        case (state_r)
          I2C_ADDR: begin
            if (addrHit) begin
              sdaOeN_r <= 1'b0;
              state_r <= rxSh_r[0] ? I2C_RDATA : I2C_CMD;
            end else begin
              state_r <= I2C_SKIP;
            end
          end
          I2C_CMD: begin
            cmd_r <= rxSh_r;
            sdaOeN_r <= 1'b0;
            state_r <= I2C_WDATA;
          end
          I2C_WDATA: begin
            // unsupported values are refused with a nack
            sdaOeN_r <= ~dataValid;
            state_r <= I2C_SKIP;
          end
          default: begin
            sdaOeN_r <= 1'b1;
          end
        endcase
      end else if (sclFall && ackPh_r) begin
        ackPh_r <= 1'b0;
        if (state_r == I2C_RDATA) begin
          sdaOeN_r <= rdVal[7];
          txSh_r <= {rdVal[6:0], 1'b0};
        end else begin
          sdaOeN_r <= 1'b1;
        end
      end else if (sclFall && state_r == I2C_RDATA) begin
        sdaOeN_r <= txSh_r[7];
        txSh_r <= {txSh_r[6:0], 1'b0};
      end
    end
  end

  // command registers; defaults come back on every reset
  always_ff @(posedge i2cSampleClk) begin
    if (!linkRstN) begin
      opLink_r <= OP_RESET;
      cfgLink_r <= CFG_RESET;
      wrTgl_r <= 1'b0;
    end else if (wrNow) begin
      if (cmd_r == CMD_OPERATION) begin
        opLink_r <= rxSh_r;
      end else begin
        cfgLink_r <= rxSh_r;
      end
      wrTgl_r <= ~wrTgl_r;
    end
  end

  assign sdaOut = 1'b0;
  assign sdaOeN = sdaOeN_r;
  assign ctrlAddr = ctrlAddr_r;
  assign muxAddr = muxAddr_r;
  assign moduleAddr = MODULE_ADDR;

  // core domain: protection, shared pins and leds
  logic [2:0] tglPipe;
  logic [7:0] opCore_r;
  logic [7:0] cfgCore_r;
  logic enPipe1;
  logic enPipe2;
  logic mrPipe1;
  logic mrPipe2;
  logic muxResetN_r;
  pscs_mod_s [NUM_MODULES-1:0] modPipe1;
  pscs_mod_s [NUM_MODULES-1:0] modPipe2;
  logic [NUM_MODULES-1:0] opVec;
  logic [NUM_MODULES-1:0] igVec;
  logic [NUM_MODULES-1:0] presVec;
  logic startGate_r;
  logic mainOn_r;
  logic pinOk;
  logic cmdOk;
  logic powerGoodOeN_r;
  logic inputGoodOeN_r;
  logic [CNT_W-1:0] blinkCnt_r;
  logic blinkHalf_r;
  logic [1:0] blinkThird_r;

  // data words stay still for many link edges after each toggle
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      tglPipe <= 3'h0;
      opCore_r <= OP_RESET;
      cfgCore_r <= CFG_RESET;
    end else begin
      tglPipe <= {tglPipe[1:0], wrTgl_r};
      if (tglPipe[2] != tglPipe[1]) begin
        opCore_r <= opLink_r;
        cfgCore_r <= cfgLink_r;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      enPipe1 <= 1'b1;
      enPipe2 <= 1'b1;
      mrPipe1 <= 1'b1;
      mrPipe2 <= 1'b1;
      muxResetN_r <= 1'b1;
      modPipe1 <= '0;
      modPipe2 <= '0;
    end else begin
      enPipe1 <= shelfEnableN;
      enPipe2 <= enPipe1;
      mrPipe1 <= muxResetReqN;
      mrPipe2 <= mrPipe1;
      muxResetN_r <= mrPipe2;
      modPipe1 <= moduleStatus;
      modPipe2 <= modPipe1;
    end
  end

  // pin and command gating follow the on/off configuration bits
  assign pinOk = cfgCore_r[CFG_PIN_BIT] ? ~enPipe2 : 1'b1;
  assign cmdOk = cfgCore_r[CFG_CMD_BIT] ? opCore_r[OP_ON_BIT] : 1'b1;

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      startGate_r <= 1'b0;
      mainOn_r <= 1'b0;
      powerGoodOeN_r <= 1'b1;
      inputGoodOeN_r <= 1'b1;
    end else begin
      if (igVec == '0) begin
        startGate_r <= 1'b0;
      end else if ((presVec & ~igVec) == '0) begin
        startGate_r <= 1'b1;
      end
      mainOn_r <= startGate_r & pinOk & cmdOk;
      powerGoodOeN_r <= ~|opVec;
      inputGoodOeN_r <= ~|igVec;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      blinkCnt_r <= '0;
      blinkHalf_r <= 1'b0;
      blinkThird_r <= 2'h0;
    end else if (blinkCnt_r >= BLINK_LIM - CNT_W'(1)) begin
      blinkCnt_r <= '0;
      blinkHalf_r <= ~blinkHalf_r;
      blinkThird_r <= (blinkThird_r == 2'h2) ? 2'h0 : blinkThird_r + 2'h1;
    end else begin
      blinkCnt_r <= blinkCnt_r + CNT_W'(1);
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < NUM_MODULES; gi++) begin : gModule
      pscs_mod_s ms;
      logic [CNT_W-1:0] ocCnt_r;
      logic [CNT_W-1:0] scCnt_r;
      logic [CNT_W-1:0] olCnt_r;
      logic [CNT_W-1:0] hicCnt_r;
      logic ocFire;
      logic scFire;
      logic olFire;
      logic mainSet;
      logic mainLatch_r;
      logic stbyLatch_r;
      logic hiccup_r;
      logic enN_r;
      pscs_led_s led_r;

      assign ms = modPipe2[gi];
      assign opVec[gi] = ms.operating;
      assign igVec[gi] = ms.inputGood;
      assign presVec[gi] = ms.present;
      assign ocFire = ms.ocMain && (ocCnt_r >= OC_BLANK_LIM - CNT_W'(1));
      assign scFire = ms.scMain && (scCnt_r >= SC_LATCH_LIM - CNT_W'(1));
      assign olFire = ms.overload && (olCnt_r >= OVERLOAD_LIM - CNT_W'(1));
      assign mainSet = ms.ovMain | ocFire | scFire | olFire;

      always_ff @(posedge core_clk) begin
        if (!resetn) begin
          ocCnt_r <= '0;
          scCnt_r <= '0;
          olCnt_r <= '0;
        end else begin
          ocCnt_r <= ms.ocMain ? ocCnt_r + CNT_W'(1) : '0;
          scCnt_r <= ms.scMain ? scCnt_r + CNT_W'(1) : '0;
          olCnt_r <= ms.overload ? olCnt_r + CNT_W'(1) : '0;
        end
      end

      // a new fault wins over the clear from a high shelf enable
      always_ff @(posedge core_clk) begin
        if (!resetn) begin
          mainLatch_r <= 1'b0;
          stbyLatch_r <= 1'b0;
        end else begin
          mainLatch_r <= mainSet | (mainLatch_r & ~enPipe2);
          stbyLatch_r <= ms.ovStby | (stbyLatch_r & ~enPipe2);
        end
      end

      always_ff @(posedge core_clk) begin
        if (!resetn) begin
          hicCnt_r <= '0;
          hiccup_r <= 1'b0;
        end else if (hicCnt_r != '0) begin
          hicCnt_r <= hicCnt_r - CNT_W'(1);
          if (hicCnt_r == CNT_W'(1)) begin
            hiccup_r <= 1'b0;
          end
        end else if (ms.ocStby) begin
          hicCnt_r <= HICCUP_LIM;
          hiccup_r <= 1'b1;
        end
      end

      always_ff @(posedge core_clk) begin
        if (!resetn) begin
          enN_r <= 1'b1;
          led_r <= '0;
        end else begin
          enN_r <= ~mainOn_r;
          led_r.acGreen <= ~ms.acUv;
          // first matching condition wins, in this order
          if (enN_r) begin
            led_r.dcGreen <= 1'b0;
            led_r.dcYellow <= blinkHalf_r;
          end else if (ms.outOfReg | ms.otShutdown | ms.uvShutdown |
                       mainLatch_r | stbyLatch_r | hiccup_r) begin
            led_r.dcGreen <= 1'b0;
            led_r.dcYellow <= 1'b1;
          end else if (ms.otWarn) begin
            led_r.dcGreen <= (blinkThird_r == 2'h2);
            led_r.dcYellow <= (blinkThird_r != 2'h2);
          end else if (ms.fanMinor) begin
            led_r.dcGreen <= ~blinkHalf_r;
            led_r.dcYellow <= blinkHalf_r;
          end else begin
            led_r.dcGreen <= 1'b1;
            led_r.dcYellow <= 1'b0;
          end
        end
      end

      assign moduleEnableN[gi] = enN_r;
      assign mainLatchOff[gi] = mainLatch_r;
      assign stbyLatchOff[gi] = stbyLatch_r;
      assign stbyHiccup[gi] = hiccup_r;
      assign ledState[gi] = led_r;
    end
  endgenerate

  assign muxResetN = muxResetN_r;
  assign powerGoodOut = 1'b0;
  assign powerGoodOeN = powerGoodOeN_r;
  assign inputGoodOut = 1'b0;
  assign inputGoodOeN = inputGoodOeN_r;

endmodule

//--- tb/pscs_host_model.sv
// i2c host model driving the shelf controller port
`timescale 1ns/1ps
module pscs_host_model (
  input wire logic i2cSampleClk,
  input wire logic sda,
  output logic scl,
  output logic sdaDrvN
);
  // three link periods a quarter keeps each scl phase above the minimum
  localparam int Q = 3;
  initial begin
    scl = 1'b1;
    sdaDrvN = 1'b1;
  end
  task automatic step(input logic c, input logic d);
    repeat (Q) @(posedge i2cSampleClk);
    scl <= c;
    sdaDrvN <= d;
  endtask
  task automatic bit_io(input logic d, output logic s);
    step(1'b0, d);
    step(1'b1, d);
    step(1'b1, d);
    s = sda;
    step(1'b0, d);
  endtask
  task automatic start_c;
    step(1'b0, 1'b1);
    step(1'b1, 1'b1);
    step(1'b1, 1'b0);
    step(1'b0, 1'b0);
  endtask
  task automatic stop_c;
    step(1'b0, 1'b0);
    step(1'b1, 1'b0);
    step(1'b1, 1'b1);
  endtask
  task automatic send(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(b[i], s);
    end
    bit_io(1'b1, s);
    ack = ~s;
  endtask
  task automatic recv(output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, s);
      b[i] = s;
    end
    // master nack ends the read after one byte
    bit_io(1'b1, s);
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] c, d,
      output logic [2:0] k);
    start_c;
    send({a, 1'b0}, k[2]);
    send(c, k[1]);
    send(d, k[0]);
    stop_c;
  endtask
  task automatic rd(input logic [6:0] a, input logic [7:0] c,
      output logic [7:0] d, output logic k);
    logic k1, k2, k3;
    start_c;
    send({a, 1'b0}, k1);
    send(c, k2);
    start_c;
    send({a, 1'b1}, k3);
    recv(d);
    stop_c;
    k = k1 & k2 & k3;
  endtask
endmodule

//--- tb/pscs_shelf_ctrl_monitor.sv
// assertion checker of the shelf supervisor ports
`timescale 1ns/1ps
module pscs_shelf_ctrl_monitor
  import pscs_pkg::*;
#(
  parameter logic [CNT_W-1:0] OC_BLANK_LIM = CNT_W'(OC_BLANK_CYC)
) (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic shelfEnableN,
  input wire logic muxResetReqN,
  input wire logic muxResetN,
  input pscs_mod_s [NUM_MODULES-1:0] moduleStatus,
  input wire logic [NUM_MODULES-1:0] moduleEnableN,
  input wire logic [NUM_MODULES-1:0] mainLatchOff,
  input wire logic [NUM_MODULES-1:0] stbyHiccup,
  input wire logic powerGoodOeN,
  input wire logic inputGoodOeN
);
  logic [3:0] upCnt;
  logic [CNT_W-1:0] ocRun;
  logic up, anyOp, anyIn, fault0;
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!resetn);
  // latency checks wait until the sync stages hold post-reset data
  assign up = upCnt == 4'hf;
  assign fault0 = moduleStatus[0].ovMain | moduleStatus[0].ocMain |
    moduleStatus[0].scMain | moduleStatus[0].overload;
  always_comb begin
    anyOp = 1'b0;
    anyIn = 1'b0;
    for (int i = 0; i < NUM_MODULES; i++) begin
      anyOp = anyOp | moduleStatus[i].operating;
      anyIn = anyIn | moduleStatus[i].inputGood;
    end
  end
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      upCnt <= 4'h0;
    end else if (!up) begin
      upCnt <= upCnt + 4'h1;
    end
  end
  always_ff @(posedge core_clk) begin
    if (!resetn || !moduleStatus[0].ocMain) begin
      ocRun <= '0;
    end else if (ocRun != '1) begin
      ocRun <= ocRun + CNT_W'(1);
    end
  end
  property p_pgood;
    up |-> powerGoodOeN == !$past(anyOp, 3);
  endproperty
  a_pgood: assert property (p_pgood)
    else $error("power good level wrong");
  property p_igood;
    up |-> inputGoodOeN == !$past(anyIn, 3);
  endproperty
  a_igood: assert property (p_igood)
    else $error("input good level wrong");
  property p_ovmain;
    up && moduleStatus[0].ovMain |-> ##3 mainLatchOff[0];
  endproperty
  a_ovmain: assert property (p_ovmain)
    else $error("overvoltage not latched");
  property p_hiccup;
    up && moduleStatus[0].ocStby |-> ##3 stbyHiccup[0];
  endproperty
  a_hiccup: assert property (p_hiccup)
    else $error("standby hiccup missing");
  property p_ocblank;
    ocRun == OC_BLANK_LIM + CNT_W'(6) |-> mainLatchOff[0];
  endproperty
  a_ocblank: assert property (p_ocblank)
    else $error("overcurrent not latched after blanking");
  property p_clear;
    (shelfEnableN && !fault0) [*5] |-> !mainLatchOff[0];
  endproperty
  a_clear: assert property (p_clear)
    else $error("latch not cleared by enable");
  property p_muxrst;
    up |-> muxResetN == $past(muxResetReqN, 3);
  endproperty
  a_muxrst: assert property (p_muxrst)
    else $error("mux reset does not follow request");
  property p_enoff;
    shelfEnableN [*5] |-> &moduleEnableN;
  endproperty
  a_enoff: assert property (p_enoff)
    else $error("main output on while enable high");
  c_latch: cover property ($rose(mainLatchOff[0]));
  c_hiccup: cover property ($rose(stbyHiccup[0]));
  c_pgood: cover property ($fell(powerGoodOeN));
endmodule

//--- tb/pscs_shelf_ctrl_tb.sv
// self-checking bench of the power shelf supervisor
`timescale 1ns/1ps
module pscs_shelf_ctrl_tb;
  import pscs_pkg::*;
  localparam logic [CNT_W-1:0] OC_LIM = 24'h28;
  localparam logic [CNT_W-1:0] SC_LIM = 24'h14;
  localparam logic [CNT_W-1:0] OL_LIM = 24'h1e;
  localparam logic [CNT_W-1:0] HIC_LIM = 24'ha;
  localparam logic [7:0] CFGS [5] = '{8'h01, 8'h11, 8'h15, 8'h19, 8'h1d};
  logic core_clk, resetn, i2cSampleClk, scl, hostSdaN, sdaOut, sdaOeN;
  logic shelfEnableN, muxResetReqN, muxResetN, rdAck;
  logic powerGoodOut, powerGoodOeN, inputGoodOut, inputGoodOeN;
  logic [2:0] addressSwitch, acks;
  logic [6:0] ca;
  logic [7:0] muxAddr, ctrlAddr, moduleAddr, rdData, y, g;
  logic [NUM_MODULES-1:0] moduleEnableN, mainLatchOff;
  logic [NUM_MODULES-1:0] stbyLatchOff, stbyHiccup;
  pscs_mod_s [NUM_MODULES-1:0] moduleStatus;
  pscs_led_s [NUM_MODULES-1:0] ledState;
  int n_mismatch = 0;
  int comparisons = 0;
  wire sda = hostSdaN & (sdaOeN | sdaOut);
  pscs_shelf_ctrl #(.OC_BLANK_LIM(OC_LIM), .SC_LATCH_LIM(SC_LIM),
    .OVERLOAD_LIM(OL_LIM), .HICCUP_LIM(HIC_LIM), .BLINK_LIM(24'h4))
    u_pscs_shelf_ctrl (.core_clk, .resetn, .i2cSampleClk, .sclIn(scl),
    .sdaIn(sda), .sdaOut, .sdaOeN, .shelfEnableN, .muxResetReqN,
    .muxResetN, .addressSwitch, .muxAddr, .ctrlAddr, .moduleAddr,
    .moduleStatus, .moduleEnableN, .mainLatchOff, .stbyLatchOff,
    .stbyHiccup, .ledState, .powerGoodOut, .powerGoodOeN, .inputGoodOut,
    .inputGoodOeN);
  pscs_host_model u_pscs_host_model (.i2cSampleClk, .sda, .scl,
    .sdaDrvN(hostSdaN));
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  initial begin
    i2cSampleClk = 1'b0;
    #7;
    forever #40 i2cSampleClk = ~i2cSampleClk;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  task automatic chk(input string what, input logic [7:0] e, v);
    comparisons++;
    if (v !== e) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", what, e, v);
    end
  endtask
  task automatic close_out;
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic do_reset(input logic [2:0] sw);
    addressSwitch <= sw;
    resetn <= 1'b0;
    tick(8);
    chk("ctrlAddr in reset", 8'h5e, ctrlAddr);
    chk("muxAddr in reset", 8'hee, muxAddr);
    resetn <= 1'b1;
    tick(20);
    chk("muxAddr", {4'he, sw, 1'b0}, muxAddr);
    chk("ctrlAddr", {4'h5, sw, 1'b0}, ctrlAddr);
    ca = {4'h5, sw};
  endtask
  task automatic wr_chk(input logic [6:0] a, input logic [7:0] c, d,
      input logic [2:0] ek);
    u_pscs_host_model.wr(a, c, d, acks);
    chk("write acks", {5'h0, ek}, {5'h0, acks});
  endtask
  task automatic rd_chk(input logic [7:0] c, e);
    u_pscs_host_model.rd(ca, c, rdData, rdAck);
    chk("read ack", 8'h1, {7'h0, rdAck});
    chk("read data", e, rdData);
  endtask
  task automatic pin_cycle;
    shelfEnableN <= 1'b1;
    tick(8);
    chk("enables by pin", 8'h3f, {2'h0, moduleEnableN});
    chk("cleared", 8'h0, {6'h0, mainLatchOff[0], stbyLatchOff[0]});
    shelfEnableN <= 1'b0;
    tick(8);
  endtask
  task automatic timed_latch(input int b, input int lim);
    moduleStatus[0][b] <= 1'b1;
    tick(lim - 2);
    chk("latch early", 8'h0, {7'h0, mainLatchOff[0]});
    tick(10);
    chk("latch late", 8'h1, {7'h0, mainLatchOff[0]});
    moduleStatus[0][b] <= 1'b0;
    pin_cycle;
  endtask
  task automatic led_count(input logic [7:0] ey, eg);
    y = 8'h0;
    g = 8'h0;
    tick(12);
    // 120 cycles hold whole periods of every blink step near the limit
    repeat (120) begin
      @(posedge core_clk);
      y = y + {7'h0, ledState[0].dcYellow};
      g = g + {7'h0, ledState[0].dcGreen};
    end
    chk("yellow count", ey, y);
    chk("green count", eg, g);
  endtask
  initial begin
    resetn = 1'b0;
    shelfEnableN = 1'b0;
    muxResetReqN = 1'b1;
    addressSwitch = 3'h0;
    moduleStatus = '0;
    for (int i = 0; i < NUM_MODULES; i++) begin
      moduleStatus[i].present = 1'b1;
      moduleStatus[i].inputGood = i != 3;
    end
    for (int s = 0; s < 8; s++) begin
      do_reset(3'(s));
    end
    chk("start held", 8'h3f, {2'h0, moduleEnableN});
    chk("input good", 8'h0, {7'h0, inputGoodOeN});
    chk("power good idle", 8'h1, {7'h0, powerGoodOeN});
    chk("drive levels", 8'h0, {5'h0, sdaOut, powerGoodOut, inputGoodOut});
    chk("module address", 8'h20, moduleAddr);
    moduleStatus[3].inputGood <= 1'b1;
    tick(8);
    chk("start together", 8'h0, {2'h0, moduleEnableN});
    wr_chk(ca, 8'h02, 8'h11, 3'h7);
    do_reset(3'h5);
    rd_chk(8'h02, 8'h1d);
    // the mux select write must not be claimed by the controller
    wr_chk({4'h7, 3'h5}, 8'h01, 8'h00, 3'h0);
    rd_chk(8'h01, 8'h80);
    wr_chk(7'h2f, 8'h01, 8'h00, 3'h0);
    foreach (CFGS[i]) begin
      wr_chk(ca, 8'h02, CFGS[i], 3'h7);
      rd_chk(8'h02, CFGS[i]);
    end
    wr_chk(ca, 8'h02, 8'h12, 3'h6);
    rd_chk(8'h02, 8'h1d);
    wr_chk(ca, 8'h03, 8'h55, 3'h6);
    rd_chk(8'h03, 8'h00);
    wr_chk(ca, 8'h01, 8'h40, 3'h6);
    wr_chk(ca, 8'h01, 8'h00, 3'h7);
    tick(12);
    chk("command off", 8'h3f, {2'h0, moduleEnableN});
    rd_chk(8'h01, 8'h00);
    wr_chk(ca, 8'h01, 8'h80, 3'h7);
    tick(12);
    chk("command on", 8'h0, {2'h0, moduleEnableN});
    moduleStatus[1].operating <= 1'b1;
    moduleStatus[0].ovMain <= 1'b1;
    moduleStatus[0].ovStby <= 1'b1;
    tick(4);
    moduleStatus[0].ovMain <= 1'b0;
    moduleStatus[0].ovStby <= 1'b0;
    tick(8);
    chk("power good", 8'h0, {7'h0, powerGoodOeN});
    chk("ov latch", 8'h3, {6'h0, stbyLatchOff[0], mainLatchOff[0]});
    pin_cycle;
    timed_latch(9, int'(OC_LIM));
    timed_latch(8, int'(SC_LIM));
    timed_latch(6, int'(OL_LIM));
    moduleStatus[0].ocStby <= 1'b1;
    tick(5);
    chk("hiccup", 8'h1, {7'h0, stbyHiccup[0]});
    moduleStatus[0].ocStby <= 1'b0;
    tick(int'(HIC_LIM) + 8);
    chk("hiccup end", 8'h0, {6'h0, stbyHiccup[0], stbyLatchOff[0]});
    for (int v = 0; v < 2; v++) begin
      muxResetReqN <= 1'(v);
      tick(4);
      chk("mux reset", 8'(v), {7'h0, muxResetN});
    end
    chk("led normal", 8'h6, {5'h0, ledState[0]});
    moduleStatus[0].acUv <= 1'b1;
    tick(5);
    chk("ac led", 8'h0, {7'h0, ledState[0].acGreen});
    moduleStatus[0].acUv <= 1'b0;
    moduleStatus[0].outOfReg <= 1'b1;
    tick(5);
    chk("solid yellow", 8'h5, {5'h0, ledState[0]});
    moduleStatus[0].outOfReg <= 1'b0;
    moduleStatus[0].otWarn <= 1'b1;
    moduleStatus[0].fanMinor <= 1'b1;
    led_count(8'h50, 8'h28);
    moduleStatus[0].otWarn <= 1'b0;
    led_count(8'h3c, 8'h3c);
    moduleStatus[0].otShutdown <= 1'b1;
    shelfEnableN <= 1'b1;
    led_count(8'h3c, 8'h00);
    close_out;
  end
  initial begin
    tick(60000);
    n_mismatch++;
    close_out;
  end
endmodule
bind pscs_shelf_ctrl pscs_shelf_ctrl_monitor #(.OC_BLANK_LIM(OC_BLANK_LIM))
  u_pscs_shelf_ctrl_monitor (.core_clk, .resetn, .shelfEnableN,
  .muxResetReqN, .muxResetN, .moduleStatus, .moduleEnableN, .mainLatchOff,
  .stbyHiccup, .powerGoodOeN, .inputGoodOeN);
